// *** clkgen_defines.svh ***
// Overview of operation
// - index 5: read-only revision and vendor codes
// - index 6: read-only device class and number
// - byte 7 low five bits: block-read count, default 8
// - byte 10 bit 6: keep or clear config
// - byte 11 stop code sets disabled output levels
// - per-output two-bit impedance selects in bytes 12, 13
// - per enable-input two-bit bias selects, default pull-down
// - power-good input bias in byte 16, default pull-up
// - bytes 8 and 9 reserved, read as zero
// - enable bit low forces stop-state, ignores pin
// - block read sends count, then bytes from index
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// byte indices
`define IDX_OUT_EN      8'h00
`define IDX_REV_VENDOR  8'h05
`define IDX_CLASS_NUM   8'h06
`define IDX_BYTE_COUNT  8'h07
`define IDX_PD_RESTORE  8'h0A
`define IDX_STOP        8'h0B
`define IDX_IMP_LO      8'h0C
`define IDX_IMP_HI      8'h0D
`define IDX_BIAS_LO     8'h0E
`define IDX_BIAS_HI     8'h0F
`define IDX_PG_BIAS     8'h10

// field positions (low bit of each field)
`define OUT_EN_LSB      0
`define BYTE_COUNT_LSB  0
`define PD_KEEP_BIT     6
`define PD_RSV_BIT      7
`define STOP_LSB        0
`define SEL0_LSB        2
`define SEL1_LSB        6
`define SEL2_LSB        2
`define SEL3_LSB        4
`define PG_BIAS_LSB     0

// reset values
`define RST_OUT_EN      4'hF
`define RST_BYTE_COUNT  5'h08
`define RST_KEEP        1'h1
`define RST_PD_RSV      1'h0
`define RST_STOP        2'h0
`define RST_IMP         2'h2
`define RST_OE_BIAS     2'h1
`define RST_PG_BIAS     2'h2

// stop-state codes: true/complement
`define STOP_LOW_LOW    2'h0
`define STOP_HIZ        2'h1
`define STOP_HIGH_LOW   2'h2
`define STOP_LOW_HIGH   2'h3

// identity values are arbitrary
`define REV_CODE        4'h3
`define VENDOR_CODE     4'h9
`define CLASS_CODE      2'h1
`define DEVICE_NUMBER   6'h2A

`define BITS_PER_BYTE   4'h8
`define ZERO_BYTE       8'h00

`endif

// *** clkgen_pkg.sv ***
`default_nettype none
package clkgen_pkg;

  typedef struct packed {
    logic [3:0]      out_en;
    logic [4:0]      byte_count;
    logic            pd_rsv;
    logic            keep_config_in_sleep;
    logic [1:0]      stop_code;
    logic [3:0][1:0] impedance;
    logic [3:0][1:0] enable_bias;
    logic [1:0]      power_good_bias;
  } cfg_t;

  typedef struct packed {
    logic [3:0][1:0] impedance;
    logic [3:0][1:0] enable_bias;
    logic [1:0]      power_good_bias;
  } pad_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_HACK = 5'h10
  } bus_state_t;

  typedef enum logic [1:0] {
    PH_ADDR  = 2'h0,
    PH_INDEX = 2'h1,
    PH_COUNT = 2'h2,
    PH_DATA  = 2'h3
  } bus_phase_t;

endpackage : clkgen_pkg
`default_nettype wire

// *** diff_out_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "clkgen_defines.svh"
module diff_out_ctrl (
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_ref_clk,
  input  wire logic       i_sw_enable,
  input  wire logic       i_oe_pin_n,
  input  wire logic       i_running,
  input  wire logic [1:0] i_stop_code,
  output var  logic       o_true,
  output var  logic       o_comp,
  output var  logic       o_drive
);
  logic true_d, comp_d, drive_d;
  logic true_q, comp_q, drive_q;

  always_comb begin
    true_d  = 1'b0;
    comp_d  = 1'b0;
    drive_d = 1'b1;
    // software disable overrides the pin entirely
    if (i_running && i_sw_enable && !i_oe_pin_n) begin
      true_d = i_ref_clk;
      comp_d = ~i_ref_clk;
    end else begin
      unique case (i_stop_code)
        `STOP_LOW_LOW:  drive_d = 1'b1;
        `STOP_HIZ:      drive_d = 1'b0;
        `STOP_HIGH_LOW: true_d  = 1'b1;
        `STOP_LOW_HIGH: comp_d  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      true_q  <= 1'b0;
      comp_q  <= 1'b0;
      drive_q <= 1'b1;
    end else begin
      true_q  <= true_d;
      comp_q  <= comp_d;
      drive_q <= drive_d;
    end
  end

  assign o_true  = true_q;
  assign o_comp  = comp_q;
  assign o_drive = drive_q;
endmodule : diff_out_ctrl
`default_nettype wire

// *** clock_gen_config_registers.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "clkgen_defines.svh"
module clock_gen_config_registers
  import clkgen_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic [6:0] i_dev_addr,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output var  logic       o_sda_out,
  output var  logic       o_sda_oe,
  input  wire logic       i_ref_clk,
  input  wire logic [3:0] i_oe_pin_n,
  input  wire logic       i_power_good_powerdown_input,
  output var  logic [3:0] o_diff_true,
  output var  logic [3:0] o_diff_comp,
  output var  logic [3:0] o_diff_drive,
  output var  pad_cfg_t   o_pad_cfg
);

  // ---------------- bus pin sampling ----------------
  logic scl_q, sda_q;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  assign start_ev = i_scl && scl_q && sda_q && !i_sda;
  assign stop_ev  = i_scl && scl_q && !sda_q && i_sda;
  assign scl_rise = i_scl && !scl_q;
  assign scl_fall = !i_scl && scl_q;

  // ---------------- bus engine state ----------------
  bus_state_t state_q, state_d;
  bus_phase_t phase_q, phase_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] index_q, index_d;
  logic       read_q, read_d;
  logic       hack_q, hack_d;
  logic       sda_oe_q, sda_oe_d;
  logic [6:0] addr_q, addr_d;
  logic       addr_armed_q, addr_armed_d;

  logic       wr_en;
  logic [7:0] wr_index;
  logic [7:0] wr_data;

  cfg_t cfg_q, cfg_d;

  function automatic cfg_t cfg_default();
    cfg_t c;
    c.out_en               = `RST_OUT_EN;
    c.byte_count           = `RST_BYTE_COUNT;
    c.pd_rsv               = `RST_PD_RSV;
    c.keep_config_in_sleep = `RST_KEEP;
    c.stop_code            = `RST_STOP;
    c.impedance            = {4{`RST_IMP}};
    c.enable_bias          = {4{`RST_OE_BIAS}};
    c.power_good_bias      = `RST_PG_BIAS;
    return c;
  endfunction : cfg_default

  // unmapped and reserved bytes read as zero
  function automatic logic [7:0] read_byte(input cfg_t c, input logic [7:0] idx);
    logic [7:0] b;
    b = `ZERO_BYTE;
    unique case (idx)
      `IDX_OUT_EN:     b[`OUT_EN_LSB +: 4] = c.out_en;
      `IDX_REV_VENDOR: b = {`REV_CODE, `VENDOR_CODE};
      `IDX_CLASS_NUM:  b = {`CLASS_CODE, `DEVICE_NUMBER};
      `IDX_BYTE_COUNT: b[`BYTE_COUNT_LSB +: 5] = c.byte_count;
      `IDX_PD_RESTORE: begin
        b[`PD_KEEP_BIT] = c.keep_config_in_sleep;
        b[`PD_RSV_BIT]  = c.pd_rsv;
      end
      `IDX_STOP:       b[`STOP_LSB +: 2] = c.stop_code;
      `IDX_IMP_LO: begin
        b[`SEL0_LSB +: 2] = c.impedance[0];
        b[`SEL1_LSB +: 2] = c.impedance[1];
      end
      `IDX_IMP_HI: begin
        b[`SEL2_LSB +: 2] = c.impedance[2];
        b[`SEL3_LSB +: 2] = c.impedance[3];
      end
      `IDX_BIAS_LO: begin
        b[`SEL0_LSB +: 2] = c.enable_bias[0];
        b[`SEL1_LSB +: 2] = c.enable_bias[1];
      end
      `IDX_BIAS_HI: begin
        b[`SEL2_LSB +: 2] = c.enable_bias[2];
        b[`SEL3_LSB +: 2] = c.enable_bias[3];
      end
      `IDX_PG_BIAS:    b[`PG_BIAS_LSB +: 2] = c.power_good_bias;
      default:         b = `ZERO_BYTE;
    endcase
    return b;
  endfunction : read_byte

  always_comb begin
    state_d      = state_q;
    phase_d      = phase_q;
    bitcnt_d     = bitcnt_q;
    shift_d      = shift_q;
    index_d      = index_q;
    read_d       = read_q;
    hack_d       = hack_q;
    sda_oe_d     = sda_oe_q;
    addr_d       = addr_q;
    addr_armed_d = 1'b1;
    wr_en        = 1'b0;
    wr_index     = index_q;
    wr_data      = shift_q;
    // address strap is caught once, on the first edge after reset
    if (!addr_armed_q) begin
      addr_d = i_dev_addr;
    end
    if (start_ev) begin
      state_d  = ST_RX;
      phase_d  = PH_ADDR;
      bitcnt_d = 4'h0;
      read_d   = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_ev) begin
      state_d  = ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: ;
        ST_RX: begin
          if (scl_rise && bitcnt_q != `BITS_PER_BYTE) begin
            shift_d  = {shift_q[6:0], i_sda};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == `BITS_PER_BYTE) begin
            state_d  = ST_ACK;
            sda_oe_d = 1'b1;
            unique case (phase_q)
              PH_ADDR: begin
                if (shift_q[7:1] != addr_q) begin
                  state_d  = ST_IDLE;
                  sda_oe_d = 1'b0;
                end
                read_d = shift_q[0];
              end
              PH_INDEX: index_d = shift_q;
              PH_COUNT: ;
              PH_DATA: begin
                // every data byte is acknowledged, even if nothing is stored
                wr_en   = 1'b1;
                index_d = index_q + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bitcnt_d = 4'h0;
            if (read_q) begin
              // the count byte leads every read
              state_d  = ST_TX;
              shift_d  = {3'h0, cfg_q.byte_count};
              // count msb is always zero, so the pin stays pulled low from the ack on
              sda_oe_d = 1'b1;
            end else begin
              state_d  = ST_RX;
              sda_oe_d = 1'b0;
              if (phase_q != PH_DATA) begin
                phase_d = bus_phase_t'(phase_q + 2'h1);
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == `BITS_PER_BYTE) begin
              state_d  = ST_HACK;
              sda_oe_d = 1'b0;
            end else begin
              shift_d  = {shift_q[6:0], 1'b0};
              sda_oe_d = ~shift_q[6];
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            hack_d = ~i_sda;
          end else if (scl_fall) begin
            if (hack_q) begin
              state_d  = ST_TX;
              bitcnt_d = 4'h0;
              shift_d  = read_byte(cfg_q, index_q);
              sda_oe_d = ~shift_d[7];
              index_d  = index_q + 8'h01;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      state_q      <= ST_IDLE;
      phase_q      <= PH_ADDR;
      bitcnt_q     <= 4'h0;
      shift_q      <= 8'h00;
      index_q      <= 8'h00;
      read_q       <= 1'b0;
      hack_q       <= 1'b0;
      sda_oe_q     <= 1'b0;
      addr_q       <= 7'h00;
      addr_armed_q <= 1'b0;
    end else begin
      scl_q        <= i_scl;
      sda_q        <= i_sda;
      state_q      <= state_d;
      phase_q      <= phase_d;
      bitcnt_q     <= bitcnt_d;
      shift_q      <= shift_d;
      index_q      <= index_d;
      read_q       <= read_d;
      hack_q       <= hack_d;
      sda_oe_q     <= sda_oe_d;
      addr_q       <= addr_d;
      addr_armed_q <= addr_armed_d;
    end
  end

  // ---------------- configuration bytes ----------------
  always_comb begin
    cfg_d = cfg_q;
    if (wr_en) begin
      // identity bytes, reserved bytes and reserved bits other than byte 10 bit 7 have no storage
      unique case (wr_index)
        `IDX_OUT_EN:     cfg_d.out_en = wr_data[`OUT_EN_LSB +: 4];
        `IDX_BYTE_COUNT: cfg_d.byte_count = wr_data[`BYTE_COUNT_LSB +: 5];
        `IDX_PD_RESTORE: begin
          cfg_d.keep_config_in_sleep = wr_data[`PD_KEEP_BIT];
          cfg_d.pd_rsv               = wr_data[`PD_RSV_BIT];
        end
        `IDX_STOP:       cfg_d.stop_code = wr_data[`STOP_LSB +: 2];
        `IDX_IMP_LO: begin
          cfg_d.impedance[0] = wr_data[`SEL0_LSB +: 2];
          cfg_d.impedance[1] = wr_data[`SEL1_LSB +: 2];
        end
        `IDX_IMP_HI: begin
          cfg_d.impedance[2] = wr_data[`SEL2_LSB +: 2];
          cfg_d.impedance[3] = wr_data[`SEL3_LSB +: 2];
        end
        `IDX_BIAS_LO: begin
          cfg_d.enable_bias[0] = wr_data[`SEL0_LSB +: 2];
          cfg_d.enable_bias[1] = wr_data[`SEL1_LSB +: 2];
        end
        `IDX_BIAS_HI: begin
          cfg_d.enable_bias[2] = wr_data[`SEL2_LSB +: 2];
          cfg_d.enable_bias[3] = wr_data[`SEL3_LSB +: 2];
        end
        `IDX_PG_BIAS:    cfg_d.power_good_bias = wr_data[`PG_BIAS_LSB +: 2];
        default:         cfg_d = cfg_q;
      endcase
    end
    // power down wipes the programmed values unless told to keep them
    if (!i_power_good_powerdown_input && !cfg_q.keep_config_in_sleep) begin
      cfg_d = cfg_default();
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= cfg_default();
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ---------------- differential outputs ----------------
  for (genvar g = 0; g < 4; g++) begin : g_out
    diff_out_ctrl u_out (
      .i_clk_sys   (i_clk_sys),
      .i_resetn    (i_resetn),
      .i_ref_clk   (i_ref_clk),
      .i_sw_enable (cfg_q.out_en[g]),
      .i_oe_pin_n  (i_oe_pin_n[g]),
      .i_running   (i_power_good_powerdown_input),
      .i_stop_code (cfg_q.stop_code),
      .o_true      (o_diff_true[g]),
      .o_comp      (o_diff_comp[g]),
      .o_drive     (o_diff_drive[g])
    );
  end

  // open-drain data pin only ever pulls low
  assign o_sda_out                 = 1'b0;
  assign o_sda_oe                  = sda_oe_q;
  assign o_pad_cfg.impedance       = cfg_q.impedance;
  assign o_pad_cfg.enable_bias     = cfg_q.enable_bias;
  assign o_pad_cfg.power_good_bias = cfg_q.power_good_bias;

endmodule : clock_gen_config_registers
`default_nettype wire

// *** clock_gen_config_registers_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module clock_gen_config_registers_chk
  import clkgen_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  input wire logic       i_scl,
  input wire logic       i_ref_clk,
  input wire logic [3:0] i_oe_pin_n,
  input wire logic       i_power_good_powerdown_input,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic [3:0] o_diff_true,
  input wire logic [3:0] o_diff_comp,
  input wire logic [3:0] o_diff_drive,
  input wire pad_cfg_t   o_pad_cfg
);
  logic [3:0] off_now;
  logic [3:0] off_all;
  logic [3:0] moved;
  logic [3:0] off_h1, off_h2, off_h3;
  logic [3:0] true_h, comp_h;
  assign off_now = i_oe_pin_n | {4{~i_power_good_powerdown_input}};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // several samples back: a config restore in power down settles over two register stages
  always_ff @(posedge i_clk_sys) begin
    off_h1 <= off_now;
    off_h2 <= off_h1;
    off_h3 <= off_h2;
    true_h <= o_diff_true;
    comp_h <= o_diff_comp;
  end
  assign off_all = off_now & off_h1 & off_h2 & off_h3;
  assign moved   = (o_diff_true ^ true_h) | (o_diff_comp ^ comp_h);
  property p_sda_open_drain;
    o_sda_out == 1'b0;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain) else $error("data pin driven high");
  property p_oe_after_scl_low;
    $changed(o_sda_oe) |-> !$past(i_scl);
  endproperty
  a_oe_after_scl_low: assert property (p_oe_after_scl_low) else $error("data moved, clock high");
  property p_oe_steady_high;
    $rose(i_scl) |=> $stable(o_sda_oe) [*4];
  endproperty
  a_oe_steady_high: assert property (p_oe_steady_high) else $error("data unstable in high");
  property p_stop_static;
    i_scl && $past(i_scl) |-> (moved & off_all) == 4'h0;
  endproperty
  a_stop_static: assert property (p_stop_static) else $error("stopped output moved");
  property p_stop_not_high_high;
    (off_now & $past(off_now) & o_diff_true & o_diff_comp & o_diff_drive) == 4'h0;
  endproperty
  a_stop_not_high_high: assert property (p_stop_not_high_high) else $error("stop both high");
  property p_follow_ref;
    $past(i_resetn) && !$past(off_now[3]) |->
      o_diff_drive[3] && o_diff_true[3] == $past(i_ref_clk) && o_diff_comp[3] != $past(i_ref_clk);
  endproperty
  a_follow_ref: assert property (p_follow_ref) else $error("output not following ref");
  property p_pad_on_scl_low;
    $changed(o_pad_cfg) |-> !$past(i_scl) || !$past(i_power_good_powerdown_input);
  endproperty
  a_pad_on_scl_low: assert property (p_pad_on_scl_low) else $error("pad config moved");
  property p_reset_vals;
    disable iff (1'b0) !i_resetn |-> o_pad_cfg == 18'h2A956 && !o_sda_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  c_ack: cover property ($rose(o_sda_oe));
  c_hiz: cover property (!o_diff_drive[1]);
  c_sleep: cover property ($fell(i_power_good_powerdown_input));
endmodule : clock_gen_config_registers_chk
`default_nettype wire

// *** smbus_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda
);
  // open-drain host: 1 releases the line, the pull-up gives the high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w();
    repeat (6) @(posedge i_clk_sys);
  endtask : w
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    w();
    o_scl <= 1'b1;
    w();
    r = i_sda;
    o_scl <= 1'b0;
  endtask : bit_io
  task automatic start();
    o_sda <= 1'b1;
    w();
    o_scl <= 1'b1;
    w();
    o_sda <= 1'b0;
    w();
    o_scl <= 1'b0;
  endtask : start
  task automatic stop();
    o_sda <= 1'b0;
    w();
    o_scl <= 1'b1;
    w();
    o_sda <= 1'b1;
    w();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask : xfer
  task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start();
    xfer({a, 1'b0}, 1'b1, q, k[0]);
    xfer(idx, 1'b1, q, k[1]);
    xfer(8'h01, 1'b1, q, k[2]);
    xfer(d, 1'b1, q, k[3]);
    stop();
    ok = &k;
  endtask : write_reg
  task automatic read_block(input logic [6:0] a, input logic [7:0] idx, input int n,
                            output logic [7:0] q [0:15], output logic ok);
    logic [7:0] d;
    logic [2:0] k;
    logic       x;
    start();
    xfer({a, 1'b0}, 1'b1, d, k[0]);
    xfer(idx, 1'b1, d, k[1]);
    start();
    xfer({a, 1'b1}, 1'b1, d, k[2]);
    for (int i = 0; i <= n; i++) xfer(8'hFF, i == n, q[i], x);
    stop();
    ok = &k;
  endtask : read_block
endmodule : smbus_host_model
`default_nettype wire

// *** clock_gen_config_registers_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "clkgen_defines.svh"
bind clock_gen_config_registers clock_gen_config_registers_chk i_chk (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_scl(i_scl), .i_ref_clk(i_ref_clk),
  .i_oe_pin_n(i_oe_pin_n), .i_power_good_powerdown_input(i_power_good_powerdown_input),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_diff_true(o_diff_true),
  .o_diff_comp(o_diff_comp), .o_diff_drive(o_diff_drive), .o_pad_cfg(o_pad_cfg));
module clock_gen_config_registers_test;
  import clkgen_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h6A;
  localparam logic [17:0] PAD_SET = {8'h64, 8'h0B, 2'h1};
  localparam logic [7:0] DFLT [5:16] = '{{`REV_CODE, `VENDOR_CODE},
    {`CLASS_CODE, `DEVICE_NUMBER}, 8'h08, 8'h00, 8'h00, 8'h40, 8'h00, 8'h88, 8'h28, 8'h44,
    8'h14, 8'h02};
  localparam logic [7:0] MASK [5:16] = '{8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'hC0, 8'h03,
    8'hCC, 8'h3C, 8'hCC, 8'h3C, 8'h03};
  logic       clk, resetn, scl, host_sda, ref_clk, pg, sda_oe;
  wire logic  sda;
  logic [3:0] oe_pin_n, d_true, d_comp, d_drive;
  pad_cfg_t   pad;
  logic [7:0] exp_mem [5:16];
  int         bad_count, num_checks, cycles;
  assign sda = host_sda & ~sda_oe;
  clock_gen_config_registers i_clock_gen_config_registers (.i_clk_sys(clk), .i_resetn(resetn),
    .i_dev_addr(DEV_ADDR), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_ref_clk(ref_clk), .i_oe_pin_n(oe_pin_n), .i_power_good_powerdown_input(pg),
    .o_diff_true(d_true), .o_diff_comp(d_comp), .o_diff_drive(d_drive), .o_pad_cfg(pad));
  smbus_host_model i_smbus_host_model (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl),
    .o_sda(host_sda));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic settle(input int n);
    // reads after this see what was registered before the last edge
    repeat (n) @(posedge clk);
  endtask : settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ok;
    i_smbus_host_model.write_reg(DEV_ADDR, idx, d, ok);
    chk(18'(ok), 18'h1);
    if (idx inside {[5:16]}) exp_mem[idx] = exp_mem[idx] & ~MASK[idx] | d & MASK[idx];
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input int n);
    logic [7:0] q [0:15];
    logic       ok;
    i_smbus_host_model.read_block(DEV_ADDR, idx, n, q, ok);
    chk(18'(ok), 18'h1);
    chk(18'(q[0]), 18'(exp_mem[7][4:0]));
    for (int i = 1; i <= n; i++) chk(18'(q[i]), 18'(exp_mem[idx + i - 1]));
  endtask : rd_chk
  task automatic t_readonly();
    logic ok;
    i_smbus_host_model.write_reg(DEV_ADDR ^ 7'h01, 8'h07, 8'h05, ok);
    chk(18'(ok), 18'h0);
    wr(8'h05, 8'hFF);
    wr(8'h06, 8'h00);
    wr(8'h08, 8'hFF);
    wr(8'h09, 8'hFF);
    wr(8'h07, 8'hFF);
    rd_chk(8'h05, 12);
  endtask : t_readonly
  task automatic t_stop_codes();
    logic [2:0] want [0:3] = '{3'b100, 3'b000, 3'b110, 3'b101};
    oe_pin_n <= 4'h2;
    for (int c = 0; c < 4; c++) begin
      wr(8'h0B, 8'hFC | 8'(c));
      settle(4);
      if (c == 1) chk(18'(d_drive[1]), 18'h0);
      else chk(18'({d_drive[1], d_true[1], d_comp[1]}), 18'(want[c]));
    end
    oe_pin_n <= 4'h0;
    wr(8'h00, 8'h0E);
    settle(4);
    chk(18'({d_drive[0], d_true[0], d_comp[0]}), 18'h5);
    settle(5);
    chk(18'({d_drive[0], d_true[0], d_comp[0]}), 18'h5);
    wr(8'h00, 8'h0F);
  endtask : t_stop_codes
  task automatic t_pad();
    wr(8'h0C, 8'h73);
    wr(8'h0D, 8'hDB);
    wr(8'h0E, 8'h8C);
    wr(8'h0F, 8'h00);
    wr(8'h10, 8'hFD);
    settle(2);
    chk(pad, PAD_SET);
    rd_chk(8'h0B, 6);
  endtask : t_pad
  task automatic t_powerdown();
    pg <= 1'b0;
    settle(20);
    chk(pad, PAD_SET);
    pg <= 1'b1;
    settle(4);
    wr(8'h0A, 8'h00);
    pg <= 1'b0;
    settle(6);
    chk(pad, 18'h2A956);
    pg <= 1'b1;
    exp_mem = DFLT;
    settle(4);
    rd_chk(8'h05, 12);
  endtask : t_powerdown
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) ref_clk <= ~ref_clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    resetn = 1'b1;
    ref_clk = 1'b0;
    pg = 1'b1;
    oe_pin_n = 4'h0;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    exp_mem = DFLT;
    // a real falling edge once every process runs, so the async reset is seen
    #1;
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle(4);
    rd_chk(8'h05, 12);
    rd_chk(8'h0D, 4);
    t_readonly();
    t_stop_codes();
    t_pad();
    t_powerdown();
    complete_run();
  end
endmodule : clock_gen_config_registers_test
`default_nettype wire
